/* verilog/l2arb_limits.sv */
// Backside L2 arbiter with snoop-win cap, fetch-loss promotion,
// control register and stash identifier filter.
// Assumes requesters hold a request until granted, on the same clock.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "l2arb_defs.svh"

module l2arb_limits
    import l2arb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    // Requests and grants
    input  wire l2arb_req_t  req,
    output l2arb_req_t       grant,
    // External stash
    input  wire logic        stash_valid,
    input  wire logic [7:0]  stash_tid,
    output logic             stash_accept,
    output logic             stash_reject
);

    // ==========================================================
    // Control register
    logic [31:0] ctrl;
    logic        ctrl_hit;
    logic        stat_hit;
    logic        ctrl_wr;

    assign ctrl_hit = (addr == `L2ARB_CTRL_ADDR);
    assign stat_hit = (addr == `L2ARB_STAT_ADDR);
    assign ctrl_wr  = wr_en && ctrl_hit;

    logic        fetch_dis;
    logic [1:0]  fetch_code;
    logic        snoop_dis;
    logic [2:0]  snoop_code;
    logic [7:0]  stash_id;

    assign fetch_dis  = ctrl[`L2ARB_FLD_DIS_BIT];
    assign fetch_code = ctrl[`L2ARB_FTH_HI:`L2ARB_FTH_LO];
    assign snoop_dis  = ctrl[`L2ARB_SCD_BIT];
    assign snoop_code = ctrl[`L2ARB_SCAP_HI:`L2ARB_SCAP_LO];
    assign stash_id   = ctrl[`L2ARB_SID_HI:`L2ARB_SID_LO];

    // masked store
    // Only the implemented bits are stored, eight of the identifier
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl <= `L2ARB_CTRL_RESET;
        else if (ctrl_wr)
            ctrl <= wr_data & `L2ARB_CTRL_WMASK;
    end

    // ==========================================================
    // Limit decode
    logic [4:0] fetch_thr;
    logic [7:0] snoop_cap;

    assign fetch_thr = (fetch_code == 2'h0) ? `L2ARB_FETCH_DEF
                                            : (5'h02 << fetch_code);
    assign snoop_cap = (snoop_code == 3'h0) ? `L2ARB_SNOOP_DEF
                                            : (8'h01 << snoop_code);

    // ==========================================================
    // Arbitration
    logic [4:0] loss_cnt;
    logic [7:0] win_cnt;
    logic       others_pend;
    logic       snoop_block;
    logic       snoop_win;
    logic       fetch_prom;
    l2arb_req_t next_grant;

    assign others_pend = req.fetch || req.lsu || req.misc;

    assign snoop_block = !snoop_dis && others_pend
                         && (win_cnt >= snoop_cap);
    assign snoop_win   = req.snoop && !snoop_block;
    assign fetch_prom  = !fetch_dis && (loss_cnt >= fetch_thr);

    // Fetch is the lowest non-snoop unit until promoted, so that a
    // busy load/store path is what makes it lose.
    always_comb
    begin
        next_grant = '0;
        if (snoop_win)
            next_grant.snoop = 1'b1;
        else if (req.fetch && fetch_prom)
            next_grant.fetch = 1'b1;
        else if (req.lsu)
            next_grant.lsu = 1'b1;
        else if (req.misc)
            next_grant.misc = 1'b1;
        else if (req.fetch)
            next_grant.fetch = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            grant <= '0;
        else
            grant <= next_grant;
    end

    // ==========================================================
    // Loss and win counters
    logic       nonsnoop_gnt;
    logic       fetch_lost;
    logic [4:0] next_loss;
    logic [7:0] next_win;

    assign nonsnoop_gnt = next_grant.fetch || next_grant.lsu
                          || next_grant.misc;
    assign fetch_lost   = req.fetch && !next_grant.fetch;

    // loss count
    // Saturates at the largest threshold; a dropped fetch request
    // breaks the run of consecutive losses.
    assign next_loss = !fetch_lost ? 5'h00
                     : (loss_cnt == 5'h10) ? loss_cnt
                     : loss_cnt + 5'h01;

    assign next_win = nonsnoop_gnt ? 8'h00
                    : !next_grant.snoop ? win_cnt
                    : (win_cnt == 8'hFF) ? win_cnt
                    : win_cnt + 8'h01;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            loss_cnt <= 5'h00;
            win_cnt  <= 8'h00;
        end
        else
        begin
            loss_cnt <= next_loss;
            win_cnt  <= next_win;
        end
    end

    // ==========================================================
    // Stash filter
    logic id_match;

    // compare
    // Software keeps the id at zero or 8 to 255; lower values are
    // not trapped here.
    assign id_match = (stash_id != 8'h00) && (stash_tid == stash_id);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stash_accept <= 1'b0;
            stash_reject <= 1'b0;
        end
        else
        begin
            stash_accept <= stash_valid && id_match;
            stash_reject <= stash_valid && !id_match;
        end
    end

    // ==========================================================
    // Read port
    logic [31:0] stat_word;
    logic [31:0] next_rd;

    assign stat_word = {15'h0000, fetch_prom, snoop_block,
                        win_cnt, loss_cnt, 2'h0};
    assign next_rd   = !rd_en   ? 32'h00000000
                     : ctrl_hit ? ctrl
                     : stat_hit ? stat_word
                     : 32'h00000000;

    always_ff @(posedge clk)
    begin
        if (srst)
            rd_data <= 32'h00000000;
        else
            rd_data <= next_rd;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_snoop_first;
        req.snoop && !snoop_block |=> grant.snoop;
    endproperty
    a_snoop_first: assert property (p_snoop_first)
        else $error("pending snoop not granted");

    property p_cap_block;
        req.snoop && snoop_block |=> !grant.snoop && !$stable(win_cnt);
    endproperty
    a_cap_block: assert property (p_cap_block)
        else $error("snoop granted past cap");

    property p_cap_off;
        snoop_dis && req.snoop |=> grant.snoop;
    endproperty
    a_cap_off: assert property (p_cap_off)
        else $error("snoop capped while cap disabled");

    property p_cap_two;
        !snoop_dis && snoop_code == 3'h1 && win_cnt == 8'h02
            && others_pend |-> snoop_block;
    endproperty
    a_cap_two: assert property (p_cap_two)
        else $error("cap code 001 not two");

    property p_fetch_prom;
        req.fetch && fetch_prom && !snoop_win |=> grant.fetch;
    endproperty
    a_fetch_prom: assert property (p_fetch_prom)
        else $error("promoted fetch not granted");

    property p_fetch_off;
        fetch_dis |-> !fetch_prom;
    endproperty
    a_fetch_off: assert property (p_fetch_off)
        else $error("fetch promoted while disabled");

    property p_thr_four;
        !fetch_dis && fetch_code == 2'h1 && loss_cnt == 5'h04
            |-> fetch_prom;
    endproperty
    a_thr_four: assert property (p_thr_four)
        else $error("threshold code 01 not four");

    property p_loss_clear;
        grant.fetch |-> loss_cnt == 5'h00;
    endproperty
    a_loss_clear: assert property (p_loss_clear)
        else $error("loss count kept after fetch grant");

    property p_stash_ok;
        stash_valid && stash_tid == stash_id && stash_id != 8'h00
            |=> stash_accept && !stash_reject;
    endproperty
    a_stash_ok: assert property (p_stash_ok)
        else $error("matching stash not accepted");

    property p_stash_zero;
        stash_valid && stash_id == 8'h00 |=> stash_reject;
    endproperty
    a_stash_zero: assert property (p_stash_zero)
        else $error("stash taken with zero id");

    property p_id_store;
        ctrl_wr |=> stash_id == $past(wr_data[7:0]);
    endproperty
    a_id_store: assert property (p_id_store)
        else $error("stash id not stored");

    property p_rsvd;
        $past(rd_en) && $past(ctrl_hit)
            |-> (rd_data & ~`L2ARB_CTRL_WMASK) == 32'h00000000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");

    property p_reset_codes;
        disable iff (1'b0)
        $past(srst) && !srst |-> fetch_code == 2'h0 && snoop_code == 3'h0;
    endproperty
    a_reset_codes: assert property (p_reset_codes)
        else $error("limit codes not zero after reset");

endmodule : l2arb_limits

/* pkg/l2arb_defs.svh */
// Offsets, field positions, reset values and decode constants of the
// backside L2 arbitration limiter. Assumes a 32-bit register port.
`ifndef L2ARB_DEFS_SVH
`define L2ARB_DEFS_SVH

// ==========================================================
// Register offsets
`define L2ARB_CTRL_ADDR     8'h00
`define L2ARB_STAT_ADDR     8'h04

// ==========================================================
// Control field positions
`define L2ARB_FLD_DIS_BIT   31
`define L2ARB_FTH_HI        29
`define L2ARB_FTH_LO        28
`define L2ARB_SCD_BIT       27
`define L2ARB_SCAP_HI       26
`define L2ARB_SCAP_LO       24
`define L2ARB_SID_HI        7
`define L2ARB_SID_LO        0

// ==========================================================
// Reset and write mask
`define L2ARB_CTRL_RESET    32'h00000000
`define L2ARB_CTRL_WMASK    32'hBF0000FF

// ==========================================================
// Decode defaults for code zero
`define L2ARB_FETCH_DEF     5'h08
`define L2ARB_SNOOP_DEF     8'h08
`endif

/* pkg/l2arb_pkg.sv */
// Types shared by the arbitration limiter.
// Assumes the requesters are logic on the same core clock.
package l2arb_pkg;
    // One bit per requester of the backside L2
    typedef struct packed {
        logic snoop;
        logic fetch;
        logic lsu;
        logic misc;
    } l2arb_req_t;
endpackage : l2arb_pkg

/* test/l2arb_req_model.sv */
// Core requesters of the backside L2: each raises a request on demand
// and holds it until the arbiter grants it. Assumes one clock with the arbiter.
`timescale 1ns/1ps
module l2arb_req_model
    import l2arb_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Demand and arbitration
    input  wire logic [3:0] want,
    input  wire l2arb_req_t grant,
    output l2arb_req_t      req
);
    // ==========================================================
    // Request hold
    // A losing requester keeps asking, so nothing is dropped unserved
    always_ff @(posedge clk)
    begin
        if (srst)
            req <= '0;
        else
            req <= want | (req & ~grant);
    end
endmodule : l2arb_req_model

/* test/l2arb_limits_tb_top.sv */
// Self-checking bench of the L2 arbitration limiter.
// Assumes a 25 MHz clock and requesters modelled by l2arb_req_model.
`timescale 1ns/1ps
`include "l2arb_defs.svh"
module l2arb_limits_tb_top
    import l2arb_pkg::*;
;
    logic        clk = 0, srst = 1, wr_en = 0, rd_en = 0, stash_valid = 0;
    logic [7:0]  addr = '0, stash_tid = '0;
    logic [31:0] wr_data = '0, rd_data;
    logic [3:0]  want = '0;
    l2arb_req_t  req, grant;
    logic        stash_accept, stash_reject;
    int          errors = 0, check_count = 0;

    always #20 clk = ~clk;

    l2arb_limits DUT (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .req(req), .grant(grant),
        .stash_valid(stash_valid), .stash_tid(stash_tid), .stash_accept(stash_accept),
        .stash_reject(stash_reject));
    l2arb_req_model PEER (.clk(clk), .srst(srst), .want(want), .grant(grant), .req(req));

    // ==========================================================
    // Shared tasks
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk

    task step;
        @(posedge clk);
        #1;
    endtask : step

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wr_data <= d; wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a; rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(name, exp, rd_data);
    endtask : rd

    // Grants other than bit s, counted between two grants of bit s
    task between(input int s, output int n);
        int k;
        n = 0;
        for (k = 0; k < 300 && grant[s] !== 1'b1; k++) step();
        step();
        for (k = 0; k < 300 && grant[s] !== 1'b1; k++)
        begin
            if (grant !== 4'h0) n++;
            step();
        end
        if (k == 300) chk("grant wait", 32'h1, 32'h0);
    endtask : between

    task stash(input logic [7:0] t, input logic acc);
        @(posedge clk);
        stash_valid <= 1'b1; stash_tid <= t;
        @(posedge clk);
        stash_valid <= 1'b0;
        #1;
        chk("stash_accept", {31'h0, acc}, {31'h0, stash_accept});
        chk("stash_reject", {31'h0, ~acc}, {31'h0, stash_reject});
    endtask : stash

    // ==========================================================
    // Scenarios
    task t_regs;
        rd("ctrl reset", `L2ARB_CTRL_ADDR, 32'h00000000);
        wr(`L2ARB_CTRL_ADDR, 32'hFFFFFFFF);
        rd("ctrl mask", `L2ARB_CTRL_ADDR, `L2ARB_CTRL_WMASK);
        // Mid-run reset must bring both limit codes back to their defaults
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd("ctrl after reset", `L2ARB_CTRL_ADDR, 32'h00000000);
        rd("unmapped", 8'h08, 32'h00000000);
        $display("test regs done");
    endtask : t_regs

    task t_snoop;
        int c, n;
        for (c = 0; c < 8; c++)
        begin
            want <= 4'h0;
            wr(`L2ARB_CTRL_ADDR, 32'(c) << 24);
            want <= 4'hA;
            between(1, n);
            chk("snoop wins", (c == 0) ? 32'h8 : 32'h1 << c, 32'(n));
        end
        want <= 4'h0;
        wr(`L2ARB_CTRL_ADDR, 32'h09000000);
        want <= 4'hA;
        // Let leftover requests drain before every cycle is judged
        repeat (4) step();
        repeat (136)
        begin
            step();
            chk("snoop alone", 32'h8, {28'h0, grant});
        end
        want <= 4'h0;
        $display("test snoop done");
    endtask : t_snoop

    task t_fetch;
        int c, n;
        logic [31:0] th[4];
        th = '{32'h8, 32'h4, 32'h8, 32'h10};
        for (c = 0; c < 4; c++)
        begin
            want <= 4'h0;
            wr(`L2ARB_CTRL_ADDR, 32'(c) << 28);
            want <= 4'h6;
            between(2, n);
            chk("fetch losses", th[c], 32'(n));
        end
        want <= 4'h0;
        wr(`L2ARB_CTRL_ADDR, 32'h80000000);
        want <= 4'h6;
        repeat (40)
        begin
            step();
            chk("fetch held", 32'h0, {31'h0, grant.fetch});
        end
        // Loss count saturated at 16 and still no promotion
        rd("status", `L2ARB_STAT_ADDR, 32'h00000040);
        want <= 4'h0;
        $display("test fetch done");
    endtask : t_fetch

    task t_stash;
        wr(`L2ARB_CTRL_ADDR, 32'h00000000);
        stash(8'h00, 1'b0);
        stash(8'h08, 1'b0);
        // Only legal identifiers are written
        wr(`L2ARB_CTRL_ADDR, 32'hFFFF0008);
        stash(8'h08, 1'b1);
        stash(8'hFF, 1'b0);
        wr(`L2ARB_CTRL_ADDR, 32'h000000FF);
        stash(8'hFF, 1'b1);
        $display("test stash done");
    endtask : t_stash

    // ==========================================================
    // Verdict
    task results;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_snoop();
        t_fetch();
        t_stash();
        results();
    end

    // Whole run is under a thousand cycles; twenty times that means a hang
    initial
    begin
        #(40 * 20000);
        errors++;
        results();
    end
endmodule : l2arb_limits_tb_top
